// ---- tlac_regs.svh ----
// Register map, field positions and reset values of the tile list allocation control block
`ifndef TLAC_REGS_SVH
`define TLAC_REGS_SVH
// ----------------------------------------------------------------
// Byte addresses
// ----------------------------------------------------------------
`define TLAC_ADR_ALLOC   32'h005f8140
`define TLAC_ADR_INIT    32'h005f8144
`define TLAC_ADR_YBASE   32'h005f8148
`define TLAC_ADR_YCTRL   32'h005f814c
`define TLAC_ADR_YCNT    32'h005f8150
`define TLAC_ADR_CONT    32'h005f8160
`define TLAC_ADR_NBINIT  32'h005f8164
`define TLAC_ADR_TILE0   32'h005f8600
// ----------------------------------------------------------------
// Writable bit masks and reset values
// ----------------------------------------------------------------
`define TLAC_ALLOC_MASK  32'h00133333
`define TLAC_YBASE_MASK  32'h00fffff8
`define TLAC_YCTRL_MASK  32'h01013f3f
`define TLAC_NB_MASK     32'h00ffffe0
`define TLAC_RST_ZERO    32'h00000000
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TLAC_TRIG_BIT    31
`define TLAC_DIR_BIT     20
`define TLAC_FORM_BIT    24
`define TLAC_TEX_BIT     16
`define TLAC_VSZ_MSB     13
`define TLAC_VSZ_LSB     8
`define TLAC_USZ_MSB     5
`define TLAC_USZ_LSB     0
`define TLAC_ENTRY_BIT   31
`define TLAC_NB_W        24
`define TLAC_CNT_W       13
// ----------------------------------------------------------------
// Block size codes and word counts
// ----------------------------------------------------------------
`define TLAC_SZ_NONE     2'h0
`define TLAC_SZ_8        2'h1
`define TLAC_SZ_16       2'h2
`define TLAC_WORDS_0     6'h00
`define TLAC_WORDS_8     6'h08
`define TLAC_WORDS_16    6'h10
`define TLAC_WORDS_32    6'h20
// ----------------------------------------------------------------
// 64-bit data words per macroblock part
// ----------------------------------------------------------------
`define TLAC_Y_WORDS     7'h20
`define TLAC_C420_WORDS  7'h08
`define TLAC_C422_WORDS  7'h10
`endif

// ---- tlac_pkg.sv ----
// Types shared by the tile list allocation control block
package tlac_pkg;
    // List type selecting one block size field
    typedef enum logic [2:0] {
        TLAC_OPAQUE,
        TLAC_OPAQUE_MODVOL,
        TLAC_TRANSLUCENT,
        TLAC_TRANSLUCENT_MODVOL,
        TLAC_PUNCH_THROUGH
    } tlac_list_t;
    // Component the YUV converter expects next
    typedef enum logic [1:0] {
        TLAC_PH_U,
        TLAC_PH_V,
        TLAC_PH_Y
    } tlac_phase_t;
endpackage : tlac_pkg

// ---- tlac_yuv_tracker.sv ----
// YUV converter sequencing: component phase and macroblock counter
`timescale 1ns/10ps
`include "tlac_regs.svh"
module tlac_yuv_tracker (
    input  wire logic                     i_core_clk,
    input  wire logic                     i_rst_n,
    input  wire logic                     i_restart,
    input  wire logic                     i_datum_valid,
    input  wire logic                     i_form_422,
    input  wire logic [`TLAC_CNT_W-1:0]   i_target,
    output tlac_pkg::tlac_phase_t         o_phase,
    output logic      [`TLAC_CNT_W-1:0]   o_mb_count,
    output logic                          o_done
);
    import tlac_pkg::*;

    tlac_phase_t             phase_ff, nxt_phase;  // Component expected next
    logic [6:0]              wcnt_ff, nxt_wcnt;    // Words seen in this part
    logic [`TLAC_CNT_W-1:0]  mb_ff, nxt_mb;        // Stored macroblocks
    logic                    done_ff;              // Target reached
    logic [6:0]              limit;                // Words in current part
    logic                    part_end;             // Last word of a part

    // ----------------------------------------------------------------
    // Phase and count update
    // ----------------------------------------------------------------
    assign limit    = (phase_ff == TLAC_PH_Y) ? `TLAC_Y_WORDS :
                      (i_form_422 ? `TLAC_C422_WORDS : `TLAC_C420_WORDS);  // see [R11]
    assign part_end = i_datum_valid && (wcnt_ff == limit - 7'h01);

    // Restart outranks a datum arriving in the same cycle
    always_comb begin
        nxt_phase = phase_ff;
        nxt_wcnt  = wcnt_ff;
        nxt_mb    = mb_ff;
        if (i_restart) begin
            nxt_phase = TLAC_PH_U;                // see [R09]
            nxt_wcnt  = 7'h00;
            nxt_mb    = '0;                       // see [R10]
        end else if (part_end) begin
            nxt_wcnt = 7'h00;
            case (phase_ff)
                TLAC_PH_U: nxt_phase = TLAC_PH_V;
                TLAC_PH_V: nxt_phase = TLAC_PH_Y;
                default: begin
                    nxt_phase = TLAC_PH_U;
                    // Saturate so a runaway stream cannot wrap to zero
                    if (mb_ff != '1) begin
                        nxt_mb = mb_ff + 1'b1;    // see [R10]
                    end
                end
            endcase
        end else if (i_datum_valid) begin
            nxt_wcnt = wcnt_ff + 7'h01;
        end
    end

    // State registers
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            phase_ff <= TLAC_PH_U;
            wcnt_ff  <= 7'h00;
            mb_ff    <= '0;
            done_ff  <= 1'b0;
        end else begin
            phase_ff <= nxt_phase;
            wcnt_ff  <= nxt_wcnt;
            mb_ff    <= nxt_mb;
            done_ff  <= (nxt_mb == i_target);
        end
    end

    assign o_phase    = phase_ff;
    assign o_mb_count = mb_ff;
    assign o_done     = done_ff;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_restart_to_u: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see [R09]
        i_restart |=> (o_phase == TLAC_PH_U) && (wcnt_ff == 7'h00))
        else $error("converter did not restart at U");
    a_count_clear: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see [R10]
        i_restart |=> (o_mb_count == '0))
        else $error("macroblock count not cleared");
    a_count_step: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // see [R10]
        !i_restart && !(part_end && phase_ff == TLAC_PH_Y) |=> $stable(o_mb_count))
        else $error("macroblock count moved without a full macroblock");
    c_mb_done: cover property (@(posedge i_core_clk) disable iff (!i_rst_n) $rose(o_done));
endmodule : tlac_yuv_tracker

// ---- tlac_top.sv ----
// Tile list allocation control: register bank, block pointer and per-tile words
//
// Notes on behaviour
// [R01] Overflow blocks grow up or down by direction
// [R02] Size code: absent, 8, 16, 32 words
// [R03] Five independent list block size fields
// [R04] Software sets absent code for unused lists
// [R05] Software keeps burst size within block size
// [R06] Software sets clip, allocation, init address first
// [R07] List-initialise bit 31 starts; reads zero
// [R08] Software initialises before list building starts
// [R09] Base write restarts converter at U data
// [R10] 13-bit macroblock count, cleared by base write
// [R11] Format bit 24: 4:2:0 or 4:2:2
// [R12] Texture bit: one texture or many 16x16
// [R13] Software writes size fields as pixels/16-1
// [R14] Continue reinitialises but keeps next pointer
// [R15] Software updates list base before continuing
// [R16] Init address register, reset zero, loads pointer
// [R17] 600 tile words, untouched while busy
// [R18] Tile word field layout fixed
// [R19] Entry set on registration, cleared init/end
// [R20] Run count and polygon type flags recorded
// [R21] Trigger bits are self-clearing single pulses
`timescale 1ns/10ps
`include "tlac_regs.svh"
module tlac_top #(
    parameter int TILES_X   = 40,
    parameter int TILES_Y   = 15,
    parameter int TILE_IDXW = 10
) (
    input  wire logic                     i_core_clk,
    input  wire logic                     i_rst_n,
    input  wire logic [31:0]              i_avs_address,
    input  wire logic                     i_avs_read,
    input  wire logic                     i_avs_write,
    input  wire logic [31:0]              i_avs_writedata,
    input  wire logic [3:0]               i_avs_byteenable,
    output logic      [31:0]              o_avs_readdata,
    output logic                          o_avs_waitrequest,
    input  wire logic                     i_ta_busy,
    input  wire logic                     i_block_full,
    input  tlac_pkg::tlac_list_t          i_block_list,
    input  wire logic                     i_end_of_list,
    input  wire logic                     i_tile_upd_valid,
    input  wire logic [TILE_IDXW-1:0]     i_tile_upd_index,
    input  wire logic                     i_tile_upd_quad,
    input  wire logic                     i_tile_upd_tri,
    input  wire logic [3:0]               i_tile_upd_run,
    input  wire logic                     i_tile_upd_shadow,
    input  wire logic [21:0]              i_tile_upd_next,
    input  wire logic [1:0]               i_tile_upd_skip,
    input  wire logic                     i_yuv_datum_valid,
    output logic                          o_list_init,
    output logic                          o_list_cont,
    output logic                          o_yuv_restart,
    output logic                          o_input_format_select_422,
    output logic                          o_yuv_multi_tex,
    output tlac_pkg::tlac_phase_t         o_yuv_phase,
    output logic                          o_yuv_done,
    output logic      [`TLAC_NB_W-1:0]    o_next_block_ptr
);
    import tlac_pkg::*;

    localparam int TILES = TILES_X * TILES_Y;

    // Index must reach every tile word
    if (TILES > (1 << TILE_IDXW) || TILES < 1) begin : g_chk
        $error("tile count does not fit the tile index width");
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Byte-lane merge of a bus write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // Block size code to words of 32 bits
    function automatic logic [5:0] size_words(input logic [1:0] code);
        logic [5:0] w;
        case (code)
            `TLAC_SZ_NONE: w = `TLAC_WORDS_0;     // see [R02]
            `TLAC_SZ_8:    w = `TLAC_WORDS_8;
            `TLAC_SZ_16:   w = `TLAC_WORDS_16;
            default:       w = `TLAC_WORDS_32;
        endcase
        return w;
    endfunction : size_words

    // ----------------------------------------------------------------
    // Bus handshake
    // ----------------------------------------------------------------
    logic        ack_ff;          // Second cycle of an access
    logic [31:0] rdata_ff;        // Registered read data
    logic        bus_req;         // Read or write pending
    logic        wr_take;         // Write lands at this edge
    logic        rd_load;         // Read data captured at this edge

    // Every access takes two cycles; waitrequest drops in the second
    assign bus_req           = i_avs_read || i_avs_write;
    assign o_avs_waitrequest = bus_req && !ack_ff;
    assign wr_take           = i_avs_write && ack_ff;
    assign rd_load           = i_avs_read && !ack_ff;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    logic [31:0]          tile_off;   // Offset into tile window
    logic [TILE_IDXW-1:0] tile_idx;   // Tile word selected by bus
    wire hit_alloc  = (i_avs_address == `TLAC_ADR_ALLOC);
    wire hit_init   = (i_avs_address == `TLAC_ADR_INIT);
    wire hit_ybase  = (i_avs_address == `TLAC_ADR_YBASE);
    wire hit_yctrl  = (i_avs_address == `TLAC_ADR_YCTRL);
    wire hit_ycnt   = (i_avs_address == `TLAC_ADR_YCNT);
    wire hit_cont   = (i_avs_address == `TLAC_ADR_CONT);
    wire hit_nbinit = (i_avs_address == `TLAC_ADR_NBINIT);
    assign tile_off = i_avs_address - `TLAC_ADR_TILE0;
    assign tile_idx = tile_off[TILE_IDXW+1:2];
    wire hit_tile   = (i_avs_address >= `TLAC_ADR_TILE0) && (tile_off[1:0] == 2'h0)
                   && (tile_off[31:2] < 30'(TILES));  // see [R17]

    // ----------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------
    logic [31:0] alloc_ff;        // Block sizes and growth direction
    logic [31:0] ybase_ff;        // YUV texture base, byte address on a 64-bit boundary
    logic [31:0] yctrl_ff;        // YUV format and size fields
    logic [31:0] nbinit_ff;       // Initial next-block address
    logic        init_ff;         // List-initialise pulse
    logic        cont_ff;         // List-continue pulse
    logic        yrst_ff;         // Converter restart pulse
    wire  [31:0] wd_trig = merge(`TLAC_RST_ZERO, i_avs_writedata, i_avs_byteenable);

    // Stored registers keep only their defined bits
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            alloc_ff  <= `TLAC_RST_ZERO;
            ybase_ff  <= `TLAC_RST_ZERO;
            yctrl_ff  <= `TLAC_RST_ZERO;
            nbinit_ff <= `TLAC_RST_ZERO;        // see [R16]
        end else if (wr_take) begin
            if (hit_alloc) begin
                alloc_ff <= merge(alloc_ff, i_avs_writedata, i_avs_byteenable) & `TLAC_ALLOC_MASK; // see [R03]
            end else if (hit_ybase) begin
                ybase_ff <= merge(ybase_ff, i_avs_writedata, i_avs_byteenable) & `TLAC_YBASE_MASK;
            end else if (hit_yctrl) begin
                yctrl_ff <= merge(yctrl_ff, i_avs_writedata, i_avs_byteenable) & `TLAC_YCTRL_MASK;
            end else if (hit_nbinit) begin
                nbinit_ff <= merge(nbinit_ff, i_avs_writedata, i_avs_byteenable) & `TLAC_NB_MASK;
            end
        end
    end

    // Trigger pulses last one cycle and need no clearing write
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            init_ff <= 1'b0;
            cont_ff <= 1'b0;
            yrst_ff <= 1'b0;
        end else begin
            init_ff <= wr_take && hit_init && wd_trig[`TLAC_TRIG_BIT];  // see [R07] [R21]
            cont_ff <= wr_take && hit_cont && wd_trig[`TLAC_TRIG_BIT];  // see [R14] [R21]
            yrst_ff <= wr_take && hit_ybase;                          // see [R09]
        end
    end

    assign o_list_init     = init_ff;
    assign o_list_cont     = cont_ff;
    assign o_yuv_restart   = yrst_ff;
    assign o_input_format_select_422  = yctrl_ff[`TLAC_FORM_BIT];   // see [R11]
    assign o_yuv_multi_tex = yctrl_ff[`TLAC_TEX_BIT];    // see [R12]

    // ----------------------------------------------------------------
    // Next block pointer
    // ----------------------------------------------------------------
    logic [`TLAC_NB_W-1:0] nb_ff, nxt_nb;   // Next object pointer block
    wire  [4:0]  cur_lsb   = {i_block_list[2:0], 2'h0};
    wire  [5:0]  cur_words = size_words(alloc_ff[cur_lsb +: 2]);  // see [R03]
    wire  [`TLAC_NB_W-1:0] delta = `TLAC_NB_W'({cur_words, 2'h0});
    wire         grow_down = alloc_ff[`TLAC_DIR_BIT];

    // Initialise outranks an overflow in the same cycle; continue keeps the pointer
    always_comb begin
        nxt_nb = nb_ff;
        if (init_ff) begin
            nxt_nb = nbinit_ff[`TLAC_NB_W-1:0];          // see [R16]
        end else if (i_block_full && cur_words != `TLAC_WORDS_0) begin
            nxt_nb = grow_down ? nb_ff - delta : nb_ff + delta;  // see [R01]
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            nb_ff <= '0;
        end else begin
            nb_ff <= nxt_nb;
        end
    end
    assign o_next_block_ptr = nb_ff;

    // ----------------------------------------------------------------
    // YUV converter sequencing
    // ----------------------------------------------------------------
    logic [`TLAC_CNT_W-1:0] mb_count;    // Macroblocks stored
    logic [13:0]            tgt_full;    // Macroblocks in the texture set
    assign tgt_full = ({1'b0, yctrl_ff[`TLAC_USZ_MSB:`TLAC_USZ_LSB]} + 7'h01)
                    * ({1'b0, yctrl_ff[`TLAC_VSZ_MSB:`TLAC_VSZ_LSB]} + 7'h01);  // see [R12]

    tlac_yuv_tracker u_yuv (
        .i_core_clk    (i_core_clk),
        .i_rst_n       (i_rst_n),
        .i_restart     (yrst_ff),
        .i_datum_valid (i_yuv_datum_valid),
        .i_form_422    (o_input_format_select_422),
        .i_target      (tgt_full[`TLAC_CNT_W-1:0]),
        .o_phase       (o_yuv_phase),
        .o_mb_count    (mb_count),
        .o_done        (o_yuv_done)
    );

    // ----------------------------------------------------------------
    // Per-tile pointer words
    // ----------------------------------------------------------------
    logic [30:0] tile_ff  [TILES];   // Fields below the entry bit
    logic        entry_ff [TILES];   // Entry bit per tile
    wire  [30:0] upd_word = {i_tile_upd_quad, i_tile_upd_tri, i_tile_upd_run,
                             i_tile_upd_shadow, i_tile_upd_next, i_tile_upd_skip};  // see [R18] [R20]
    wire         entry_clr = init_ff || i_end_of_list;

    // A registration in the clearing cycle keeps its entry bit set
    for (genvar g = 0; g < TILES; g++) begin : g_tile
        wire hit = i_tile_upd_valid && (i_tile_upd_index == TILE_IDXW'(g));
        always_ff @(posedge i_core_clk) begin
            if (!i_rst_n) begin
                tile_ff[g]  <= 31'h0;
                entry_ff[g] <= 1'b0;
            end else begin
                if (hit) begin
                    tile_ff[g] <= upd_word;                        // see [R20]
                end
                entry_ff[g] <= hit || (entry_ff[g] && !entry_clr); // see [R19]
            end
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    logic [31:0] rd_mux;   // Word selected for a read
    // Tile words read as zero while the accelerator runs, as their state is in flux
    wire  [31:0] tile_rd = i_ta_busy ? `TLAC_RST_ZERO
                         : {entry_ff[tile_idx], tile_ff[tile_idx]};   // see [R17]
    // Triggers and unmapped addresses read as zero
    assign rd_mux = hit_alloc  ? alloc_ff  :
                    hit_ybase  ? ybase_ff  :
                    hit_yctrl  ? yctrl_ff  :
                    hit_ycnt   ? 32'(mb_count) :                      // see [R10]
                    hit_nbinit ? nbinit_ff :
                    hit_tile   ? tile_rd   : `TLAC_RST_ZERO;          // see [R07] [R14]

    // Handshake state and captured read data
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            ack_ff   <= 1'b0;
            rdata_ff <= `TLAC_RST_ZERO;
        end else begin
            ack_ff <= bus_req && !ack_ff;
            if (rd_load) begin
                rdata_ff <= rd_mux;
            end
        end
    end
    assign o_avs_readdata = rdata_ff;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    a_trigger_one_cycle: assert property (o_list_init || o_list_cont |=> !o_list_init && !o_list_cont) // see [R21]
        else $error("trigger pulse held longer than a cycle");
    a_trigger_reads_zero: assert property (                                                   // see [R07]
        i_avs_read && !o_avs_waitrequest && (hit_init || hit_cont) |-> o_avs_readdata == 32'h0)
        else $error("trigger register read non-zero");
    a_init_loads_ptr: assert property (o_list_init |=> o_next_block_ptr == $past(nbinit_ff[`TLAC_NB_W-1:0])) // see [R16]
        else $error("pointer not loaded by initialise");
    a_cont_keeps_ptr: assert property (o_list_cont && !o_list_init && !i_block_full |=> $stable(o_next_block_ptr)) // see [R14]
        else $error("continue disturbed the pointer");
    a_growth_dir: assert property (                                                            // see [R01]
        i_block_full && !o_list_init |=> o_next_block_ptr ==
            ($past(grow_down) ? $past(nb_ff) - $past(delta) : $past(nb_ff) + $past(delta)))
        else $error("block pointer moved the wrong way");
    a_absent_list: assert property (i_block_full && !o_list_init && cur_words == 6'h00 |=> $stable(nb_ff)) // see [R02]
        else $error("absent list advanced the pointer");
    a_entry_clear: assert property ((o_list_init || i_end_of_list) && !i_tile_upd_valid |=> !entry_ff[TILES-1]) // see [R19]
        else $error("entry bit survived a clear");
    a_ybase_restart: assert property (i_avs_write && !o_avs_waitrequest && hit_ybase |=> o_yuv_restart ##2 mb_count == '0) // see [R10]
        else $error("base write did not clear the count");
    a_bus_answer: assert property (bus_req && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("bus answer took more than two cycles");

    c_init: cover property (o_list_init);
    c_cont: cover property (o_list_cont);
    c_grow_down: cover property (i_block_full && grow_down && cur_words != 6'h00);
    c_tile_read: cover property (i_avs_read && hit_tile && !o_avs_waitrequest && !i_ta_busy);
endmodule : tlac_top

// ---- tlac_top_bench.sv ----
// Self-checking testbench of the tile list allocation control block
`timescale 1ns/10ps
`include "tlac_regs.svh"
module tlac_top_bench;
    import tlac_pkg::*;
    logic        clk = 0, rst_n = 0, rd = 0, wr = 0, busy = 0, full = 0, eol = 0, upd = 0, dv = 0;
    logic [31:0] adr = 0, wd = 0, rdata, q;
    logic [30:0] tf = {1'b1, 1'b0, 4'ha, 1'b1, 22'h2aaaa5, 2'h1}; // Tile fields, bits 30-0
    logic        wt, ini, cnt, yrs, f422, mtex, done;
    logic [23:0] ptr;
    tlac_list_t  lst = TLAC_OPAQUE;
    tlac_phase_t ph;
    int          mismatches = 0, total_checks = 0;
    always #50 clk = ~clk;
    tlac_top dut_u (.i_core_clk(clk), .i_rst_n(rst_n), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wt), .i_ta_busy(busy), .i_block_full(full), .i_block_list(lst),
        .i_end_of_list(eol), .i_tile_upd_valid(upd), .i_tile_upd_index(10'd599),
        .i_tile_upd_quad(tf[30]), .i_tile_upd_tri(tf[29]), .i_tile_upd_run(tf[28:25]),
        .i_tile_upd_shadow(tf[24]), .i_tile_upd_next(tf[23:2]), .i_tile_upd_skip(tf[1:0]),
        .i_yuv_datum_valid(dv), .o_list_init(ini), .o_list_cont(cnt), .o_yuv_restart(yrs),
        .o_input_format_select_422(f422), .o_yuv_multi_tex(mtex), .o_yuv_phase(ph), .o_yuv_done(done),
        .o_next_block_ptr(ptr));
    // Compare and count; unknowns never match
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    // One Avalon transfer; held until waitrequest is sampled low at a rising edge, no fixed latency
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= w; rd <= !w; adr <= a; wd <= d;
        @(posedge clk);
        while (wt !== 1'b0) @(posedge clk);
        q = rdata;
        wr <= 1'b0; rd <= 1'b0;
    endtask : bus
    task automatic rdchk(input logic [31:0] a, input logic [31:0] e, input string s);
        bus(1'b0, a, 32'h0);
        chk(s, e, q);
    endtask : rdchk
    // Single-cycle block-full pulse for one list, then check the next block pointer
    task automatic blk(input tlac_list_t l, input logic [31:0] e);
        @(posedge clk);
        full <= 1'b1; lst <= l;
        @(posedge clk);
        full <= 1'b0;
        @(negedge clk);
        chk("block_ptr", e, {8'h0, ptr});
    endtask : blk
    task automatic give_verdict;
        if (mismatches == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : give_verdict
    // Watchdog: whole sequence needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge clk);
        mismatches++;
        give_verdict();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(`TLAC_ADR_NBINIT, 32'h0, "nbinit_rst");
        rdchk(`TLAC_ADR_YCNT, 32'h0, "count_rst");
        bus(1'b1, `TLAC_ADR_ALLOC, 32'hffffffff);
        rdchk(`TLAC_ADR_ALLOC, `TLAC_ALLOC_MASK, "alloc");
        // Unused lists get the absent code; burst size lives outside this block
        bus(1'b1, `TLAC_ADR_ALLOC, 32'h00000301);
        bus(1'b1, `TLAC_ADR_NBINIT, 32'h00001000);
        bus(1'b1, `TLAC_ADR_INIT, 32'h80000000);
        @(negedge clk) chk("init_pulse", 1, ini);
        @(negedge clk) chk("init_clear", 0, ini);
        chk("ptr_load", 32'h1000, {8'h0, ptr});
        rdchk(`TLAC_ADR_INIT, 32'h0, "init_read");
        blk(TLAC_OPAQUE, 32'h1020);
        blk(TLAC_TRANSLUCENT, 32'h10a0);
        blk(TLAC_OPAQUE_MODVOL, 32'h10a0);
        bus(1'b1, `TLAC_ADR_ALLOC, 32'h00102301);
        blk(TLAC_TRANSLUCENT_MODVOL, 32'h1060);
        // List base is kept outside this block and counts as updated here
        bus(1'b1, `TLAC_ADR_CONT, 32'h80000000);
        @(negedge clk) chk("cont_pulse", 1, cnt);
        chk("ptr_kept", 32'h1060, {8'h0, ptr});
        rdchk(`TLAC_ADR_CONT, 32'h0, "cont_read");
        // One 4:2:0 macroblock (8 U, 8 V, 32 Y words) and then 8 more U words
        @(posedge clk) dv <= 1'b1;
        repeat (56) @(posedge clk);
        dv <= 1'b0;
        rdchk(`TLAC_ADR_YCNT, 32'h1, "count_one");
        chk("yuv_done", 1, done);
        chk("phase_v", TLAC_PH_V, ph);
        bus(1'b1, `TLAC_ADR_YCTRL, 32'hffffffff);
        rdchk(`TLAC_ADR_YCTRL, `TLAC_YCTRL_MASK, "yuv_ctrl");
        chk("form_422", 1, f422);
        chk("multi_tex", 1, mtex);
        chk("done_off", 0, done);
        bus(1'b1, `TLAC_ADR_YBASE, 32'hffffffff);
        @(negedge clk) chk("yuv_restart", 1, yrs);
        rdchk(`TLAC_ADR_YBASE, `TLAC_YBASE_MASK, "yuv_base");
        rdchk(`TLAC_ADR_YCNT, 32'h0, "count_clear");
        chk("phase_u", TLAC_PH_U, ph);
        @(posedge clk) upd <= 1'b1;
        @(posedge clk) upd <= 1'b0;
        rdchk(`TLAC_ADR_TILE0 + 32'h95c, {1'b1, tf}, "tile_word");
        busy <= 1'b1;
        rdchk(`TLAC_ADR_TILE0 + 32'h95c, 32'h0, "tile_busy");
        busy <= 1'b0; eol <= 1'b1;
        @(posedge clk) eol <= 1'b0;
        rdchk(`TLAC_ADR_TILE0 + 32'h95c, {1'b0, tf}, "tile_eol");
        rdchk(32'h005f8154, 32'h0, "unmapped");
        give_verdict();
    end
endmodule : tlac_top_bench
